/* File: logic/mds_datapath.v */
// Purpose: Microcoded datapath: operand registers, ALU, transfer bus, character queue, block check, DMA address.
// Assumes: Phase strobes phase02 and dataStrobe are one clk wide, on clk; receiver inputs are asynchronous.
// Notes: Bit numbers below are decimal positions in a 16-bit word.
`timescale 1ns/1ps
`default_nettype none
`include "mds_map.vh"
module mds_datapath (
   input wire clk,
   input wire sys_rst,
   input wire [`MDS_W-1:0] microWord,
   input wire isTransfer,
   input wire isAluOp,
   input wire isRamOp,
   input wire isSetClr,
   input wire isBccCalc,
   input wire phase02,
   input wire dataStrobe,
   input wire [`MDS_W-1:0] ramOutData,
   input wire [7:0] rxChar,
   input wire rxParityErr,
   input wire rxOverrun,
   input wire rxReady,
   input wire [3:0] scanLine,
   input wire drive_address_out,
   output reg [`MDS_W-1:0] hostAddr_ff,
   output reg hostAddrOe_ff,
   output reg [1:0] hostCycle_ff,
   output reg [`MDS_W-1:0] xferBus_ff,
   output reg [`MDS_W-1:0] aluResult_ff,
   output reg [`MDS_W-1:0] block_check_result,
   output reg [`MDS_W-1:0] dma_address_reg,
   output reg charPending_ff,
   output reg rxGate_ff,
   output reg resync_ff,
   output reg fifoFull_ff,
   output reg fifoEmpty_ff,
   output reg scanAdvance_ff
);
   reg [`MDS_W-1:0] opA_ff;
   reg [`MDS_W-1:0] opB_ff;
   reg [`MDS_W-1:0] scratch_ff;
   reg [1:0] dmaCycle_ff;
   reg [`MDS_W-1:0] nxt_xfer;
   reg [7:0] rxCharS1_ff;
   reg [7:0] rxCharS2_ff;
   reg [3:0] rxFlagS1_ff;
   reg [3:0] rxFlagS2_ff;
   reg [5:0] pushCnt_ff;
   reg [`MDS_W-1:0] fifoInHold_ff;
   reg [`MDS_W-1:0] bccPoly;
   wire [`MDS_W-1:0] aluOut;
   wire [`MDS_W-1:0] fifoOut;
   wire fifoFull;
   wire fifoEmpty;
   wire [`MDS_DST_W-1:0] dstSel;
   wire [`MDS_SRC_W-1:0] srcSel;
   wire [`MDS_SC_W-1:0] scCode;
   wire [1:0] bccSel;
   wire loadStrobe;
   wire scStrobe;
   wire srcEnable;
   wire pushStart;
   wire pushPulse;
   wire rxReadyS;
   wire rxParS;
   wire rxOvrS;
   wire [`MDS_W-1:0] fifoEntry;
   wire [`MDS_W-1:0] crcA;
   wire [`MDS_W-1:0] crcB;
   wire [`MDS_W-1:0] lrcSum;
   wire [31:0] pushLoad;

   assign dstSel = microWord[`MDS_DST_LSB +: `MDS_DST_W];
   assign srcSel = microWord[`MDS_SRC_LSB +: `MDS_SRC_W];
   assign scCode = microWord[`MDS_SC_W-1:0];
   assign bccSel = ramOutData[`MDS_BCSEL_LSB +: 2];
   assign loadStrobe = isTransfer && phase02;
   assign scStrobe = isSetClr && dataStrobe;
   assign srcEnable = isTransfer || isRamOp;
   assign rxReadyS = rxFlagS2_ff[0];
   assign rxParS = rxFlagS2_ff[1];
   assign rxOvrS = rxFlagS2_ff[2];

   // Receiver pins cross two flip-flops before use.
   always @(posedge clk) begin
      if (sys_rst) begin
         rxCharS1_ff <= 8'h00;
         rxCharS2_ff <= 8'h00;
         rxFlagS1_ff <= 4'h0;
         rxFlagS2_ff <= 4'h0;
      end else begin
         rxCharS1_ff <= rxChar;
         rxCharS2_ff <= rxCharS1_ff;
         rxFlagS1_ff <= {1'b0, rxOverrun, rxParityErr, rxReady};
         rxFlagS2_ff <= rxFlagS1_ff;
      end
   end

   mds_alu u_alu (
      .opA(opA_ff),
      .opB(opB_ff),
      .func(microWord[`MDS_OP_LSB +: `MDS_OP_W]),
      .result(aluOut)
   );

   // Transfer bus source selector.
   always @* begin
      nxt_xfer = `MDS_RST_WORD;
      if (srcEnable) begin
         case (srcSel)
            `MDS_SRC_A: nxt_xfer = opA_ff;
            `MDS_SRC_B: nxt_xfer = opB_ff;
            `MDS_SRC_RES: nxt_xfer = aluResult_ff;
            `MDS_SRC_FIFO: nxt_xfer = fifoOut;
            `MDS_SRC_BCC: nxt_xfer = block_check_result;
            `MDS_SRC_DMA: nxt_xfer = dma_address_reg;
            `MDS_SRC_RXCHR: nxt_xfer = {8'h00, rxCharS2_ff};
            `MDS_SRC_SCRATCH: nxt_xfer = scratch_ff;
            `MDS_SRC_STAT: nxt_xfer = {12'h000, resync_ff, rxGate_ff, fifoFull, fifoEmpty};
            default: nxt_xfer = `MDS_RST_WORD;
         endcase
      end
   end

   // Destination loads at phase 02.
   always @(posedge clk) begin
      if (sys_rst) begin
         opA_ff <= `MDS_RST_WORD;
         opB_ff <= `MDS_RST_WORD;
         dma_address_reg <= `MDS_RST_WORD;
         dmaCycle_ff <= 2'b00;
         scratch_ff <= `MDS_RST_WORD;
         xferBus_ff <= `MDS_RST_WORD;
      end else begin
         xferBus_ff <= nxt_xfer;
         if (loadStrobe) begin
            case (dstSel)
               `MDS_DST_A: opA_ff <= nxt_xfer;
               `MDS_DST_B: opB_ff <= nxt_xfer;
               `MDS_DST_DMA: begin
                  dma_address_reg <= nxt_xfer;
                  dmaCycle_ff <= {microWord[`MDS_CYC1_BIT], microWord[`MDS_CYC0_BIT]};
               end
               `MDS_DST_SCRATCH: scratch_ff <= nxt_xfer;
               default: scratch_ff <= scratch_ff;
            endcase
         end
      end
   end

   // ALU result captured whole at the data strobe.
   always @(posedge clk) begin
      if (sys_rst) begin
         aluResult_ff <= `MDS_RST_WORD;
      end else if (isAluOp && dataStrobe) begin
         aluResult_ff[7:0] <= aluOut[7:0];
         aluResult_ff[15:8] <= aluOut[15:8];
      end
   end

   // Block check: two CRC steps of the B low byte into A, a byte sum and an XOR.
   function [`MDS_W-1:0] crcStep;
      input [`MDS_W-1:0] crc;
      input [7:0] dat;
      input [`MDS_W-1:0] poly;
      integer i;
      reg [`MDS_W-1:0] c;
      begin
         c = crc;
         for (i = 0; i < 8; i = i + 1) begin
            if (c[0] ^ dat[i]) begin
               c = (c >> 1) ^ poly;
            end else begin
               c = c >> 1;
            end
         end
         crcStep = c;
      end
   endfunction
   assign crcA = crcStep(opA_ff, opB_ff[7:0], 16'hA001);
   assign crcB = crcStep(opA_ff, opB_ff[7:0], 16'h8408);
   assign lrcSum = opA_ff + {8'h00, opB_ff[7:0]};
   always @* begin
      bccPoly = `MDS_RST_WORD;
      case (bccSel)
         2'b00: bccPoly = crcA;
         2'b01: bccPoly = crcB;
         2'b10: bccPoly = opA_ff ^ opB_ff;
         2'b11: bccPoly = lrcSum;
         default: bccPoly = `MDS_RST_WORD;
      endcase
   end
   always @(posedge clk) begin
      if (sys_rst) begin
         block_check_result <= `MDS_RST_WORD;
      end else if (isBccCalc && dataStrobe) begin
         block_check_result <= bccPoly;
      end
   end

   // Receive gate, resync flag and scan advance; set beats clear.
   always @(posedge clk) begin
      if (sys_rst) begin
         rxGate_ff <= 1'b0;
         resync_ff <= 1'b0;
         scanAdvance_ff <= 1'b0;
      end else begin
         scanAdvance_ff <= scStrobe && (scCode == `MDS_SC_SCAN_ADV);
         if (scStrobe && scCode == `MDS_SC_GATE_SET) begin
            rxGate_ff <= 1'b1;
         end else if ((scStrobe && scCode == `MDS_SC_GATE_CLR) || pushStart) begin
            rxGate_ff <= 1'b0;
         end
         if (scStrobe && scCode == `MDS_SC_RESYNC) begin
            resync_ff <= 1'b1;
         end else if (scStrobe && scCode == `MDS_SC_SCAN_ADV) begin
            resync_ff <= 1'b0;
         end
      end
   end

   // Push pulse is one cycle wide; the counter blocks new pushes for the full width; the entry is stored once at its start.
   assign fifoEntry = {resync_ff, rxOvrS, rxParS, 1'b0, scanLine, rxCharS2_ff};
   assign pushStart = scStrobe && (scCode == `MDS_SC_PUSH) && (pushCnt_ff == 6'd0);
   assign pushPulse = pushStart;
   assign pushLoad = `MDS_PUSH_CYC - 1;
   always @(posedge clk) begin
      if (sys_rst) begin
         pushCnt_ff <= 6'd0;
         fifoInHold_ff <= `MDS_RST_WORD;
      end else begin
         if (pushStart) begin
            pushCnt_ff <= pushLoad[5:0];
            fifoInHold_ff <= rxGate_ff ? fifoEntry : {resync_ff, fifoEntry[14:0]};
         end else if (pushCnt_ff != 6'd0) begin
            pushCnt_ff <= pushCnt_ff - 6'd1;
         end
      end
   end

   mds_fifo u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .push(pushPulse),
      .pop(scStrobe && (scCode == `MDS_SC_POP)),
      .dataIn(rxGate_ff ? fifoEntry : {resync_ff, fifoEntry[14:0]}),
      .dataOut(fifoOut),
      .full(fifoFull),
      .empty(fifoEmpty)
   );

   // Status and host-facing outputs.
   always @(posedge clk) begin
      if (sys_rst) begin
         charPending_ff <= 1'b0;
         fifoFull_ff <= 1'b0;
         fifoEmpty_ff <= 1'b1;
         hostAddr_ff <= `MDS_RST_WORD;
         hostAddrOe_ff <= 1'b0;
         hostCycle_ff <= 2'b00;
      end else begin
         charPending_ff <= !fifoFull && rxReadyS;
         fifoFull_ff <= fifoFull;
         fifoEmpty_ff <= fifoEmpty;
         hostAddrOe_ff <= drive_address_out;
         hostAddr_ff <= drive_address_out ? dma_address_reg : `MDS_RST_WORD;
         hostCycle_ff <= drive_address_out ? dmaCycle_ff : 2'b00;
      end
   end
endmodule // mds_datapath
`default_nettype wire

/* File: inc/mds_map.vh */
// Purpose: Constants for the microcoded multiplexer datapath.
// Assumes: Microinstruction word is 16 bits; bit numbers are decimal here.
// Notes: Timing phases arrive as one-cycle strobes from the timing generator.
`ifndef MDS_MAP_VH
`define MDS_MAP_VH
`define MDS_W 16
`define MDS_FIFO_DEPTH 128
`define MDS_FIFO_AW 7
`define MDS_OP_LSB 0
`define MDS_OP_W 6
`define MDS_SRC_LSB 4
`define MDS_SRC_W 4
`define MDS_DST_LSB 0
`define MDS_DST_W 3
`define MDS_CYC0_BIT 8
`define MDS_CYC1_BIT 9
`define MDS_BCSEL_LSB 3
`define MDS_SC_W 8
// Destination codes.
`define MDS_DST_A 3'h0
`define MDS_DST_B 3'h1
`define MDS_DST_DMA 3'h2
`define MDS_DST_SCRATCH 3'h3
// Source codes.
`define MDS_SRC_A 4'h0
`define MDS_SRC_B 4'h1
`define MDS_SRC_RES 4'h2
`define MDS_SRC_FIFO 4'h3
`define MDS_SRC_BCC 4'h4
`define MDS_SRC_DMA 4'h5
`define MDS_SRC_RXCHR 4'h6
`define MDS_SRC_SCRATCH 4'h7
`define MDS_SRC_STAT 4'h8
// Set/clear codes.
`define MDS_SC_POP 8'h10
`define MDS_SC_PUSH 8'h11
`define MDS_SC_GATE_CLR 8'h12
`define MDS_SC_GATE_SET 8'h13
`define MDS_SC_SCAN_ADV 8'h42
`define MDS_SC_RESYNC 8'h43
// Push pulse width.
`define MDS_PUSH_NS 180
`define MDS_CLK_NS 8
`define MDS_PUSH_CYC ((`MDS_PUSH_NS + `MDS_CLK_NS - 1) / `MDS_CLK_NS)
`define MDS_RST_WORD 16'h0000
`endif

/* File: logic/mds_fifo.v */
// Purpose: Received character queue, 128 entries of 16 bits.
// Assumes: Push and pop are one-cycle requests on clk.
// Notes: Output word stays put until popped; full push and empty pop are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "mds_map.vh"
module mds_fifo (
   input wire clk,
   input wire sys_rst,
   input wire push,
   input wire pop,
   input wire [`MDS_W-1:0] dataIn,
   output wire [`MDS_W-1:0] dataOut,
   output wire full,
   output wire empty
);
   reg [`MDS_W-1:0] mem [0:`MDS_FIFO_DEPTH-1];
   reg [`MDS_FIFO_AW-1:0] wrPtr_ff;
   reg [`MDS_FIFO_AW-1:0] rdPtr_ff;
   reg [`MDS_FIFO_AW:0] count_ff;
   wire doPush;
   wire doPop;
   assign full = (count_ff == `MDS_FIFO_DEPTH);
   assign empty = (count_ff == 0);
   assign doPush = push && !full;
   assign doPop = pop && !empty;
   assign dataOut = mem[rdPtr_ff];
   always @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_ff] <= dataIn;
      end
   end
   always @(posedge clk) begin
      if (sys_rst) begin
         wrPtr_ff <= 7'd0;
         rdPtr_ff <= 7'd0;
         count_ff <= 8'd0;
      end else begin
         if (doPush) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
         end
         if (doPop) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
         end
         count_ff <= count_ff + {7'h00, doPush} - {7'h00, doPop};
      end
   end
endmodule // mds_fifo
`default_nettype wire

/* File: logic/mds_alu.v */
// Purpose: Sixteen-bit operand combiner selected by a six-bit function code.
// Assumes: Code bit 5 picks logic mode, bit 4 the carry in, bits 3:0 the function.
// Notes: Purely combinational; carries ripple across the whole word.
`timescale 1ns/1ps
`default_nettype none
`include "mds_map.vh"
module mds_alu (
   input wire [`MDS_W-1:0] opA,
   input wire [`MDS_W-1:0] opB,
   input wire [`MDS_OP_W-1:0] func,
   output reg [`MDS_W-1:0] result
);
   wire cin;
   wire [`MDS_W-1:0] notB;
   assign cin = func[4];
   assign notB = ~opB;
   always @* begin
      result = `MDS_RST_WORD;
      if (func[5]) begin
         case (func[3:0])
            4'h0: result = ~opA;
            4'h1: result = ~(opA | opB);
            4'h2: result = notB & opA;
            4'h3: result = `MDS_RST_WORD;
            4'h4: result = ~(opA & opB);
            4'h5: result = notB;
            4'h6: result = opA ^ opB;
            4'h7: result = opA & notB;
            4'h8: result = ~opA | opB;
            4'h9: result = ~(opA ^ opB);
            4'hA: result = opB;
            4'hB: result = opA & opB;
            4'hC: result = 16'hFFFF;
            4'hD: result = opA | notB;
            4'hE: result = opA | opB;
            default: result = opA;
         endcase
      end else begin
         case (func[3:0])
            4'h0: result = opA + {15'h0000, cin};
            4'h1: result = opA + opB + {15'h0000, cin};
            4'h2: result = opA - opB - {15'h0000, !cin};
            4'h3: result = opB - opA - {15'h0000, !cin};
            4'h4: result = opA + opA + {15'h0000, cin};
            4'h5: result = opA - 16'h0001 + {15'h0000, cin};
            4'h6: result = (opA | opB) + {15'h0000, cin};
            4'h7: result = (opA & opB) + {15'h0000, cin};
            default: result = opA + notB + {15'h0000, cin};
         endcase
      end
   end
endmodule // mds_alu
`default_nettype wire

/* File: verif/mds_rx_model.sv */
// Purpose: Line receiver model feeding the character queue inputs.
// Assumes: Bench sets the next character and its flags; gate comes from the datapath.
// Notes: Lines not gated show the inverse of the pending character.
`timescale 1ns/1ps
`default_nettype none
module mds_rx_model (
   input wire logic gate,
   input wire logic have,
   input wire logic [7:0] nextChar,
   input wire logic nextPar,
   input wire logic nextOvr,
   output logic [7:0] rxChar,
   output logic rxParityErr,
   output logic rxOverrun,
   output logic rxReady
);
   assign rxReady = have;
   assign rxChar = gate ? nextChar : ~nextChar;
   assign rxParityErr = gate ? nextPar : ~nextPar;
   assign rxOverrun = gate ? nextOvr : ~nextOvr;
endmodule // mds_rx_model
`default_nettype wire

/* File: verif/mds_datapath_sva.sv */
// Purpose: Port timing checks for the datapath.
// Assumes: One clock, synchronous active-high reset.
// Notes: Attached to every datapath instance.
`timescale 1ns/1ps
`default_nettype none
`include "mds_map.vh"
module mds_datapath_sva (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`MDS_W-1:0] microWord,
   input wire logic isTransfer,
   input wire logic isAluOp,
   input wire logic isRamOp,
   input wire logic isSetClr,
   input wire logic isBccCalc,
   input wire logic phase02,
   input wire logic dataStrobe,
   input wire logic drive_address_out,
   input wire logic [`MDS_W-1:0] hostAddr_ff,
   input wire logic hostAddrOe_ff,
   input wire logic [1:0] hostCycle_ff,
   input wire logic [`MDS_W-1:0] xferBus_ff,
   input wire logic [`MDS_W-1:0] aluResult_ff,
   input wire logic [`MDS_W-1:0] block_check_result,
   input wire logic [`MDS_W-1:0] dma_address_reg,
   input wire logic charPending_ff,
   input wire logic rxGate_ff,
   input wire logic resync_ff,
   input wire logic fifoFull_ff,
   input wire logic fifoEmpty_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire scHit = isSetClr && dataStrobe;
   wire dmaLoad = isTransfer && phase02 && (microWord[2:0] == `MDS_DST_DMA);
   AST_DMA_HOLD: assert property (!dmaLoad |=> $stable(dma_address_reg)) else $error("dma address moved");
   AST_ADDR_OE: assert property (1'b1 |=> hostAddrOe_ff == $past(drive_address_out)) else $error("oe late");
   AST_ADDR_VAL: assert property ($past(drive_address_out) && $stable(dma_address_reg)
      |-> hostAddr_ff == dma_address_reg) else $error("address wrong");
   AST_ADDR_OFF: assert property (!hostAddrOe_ff |-> hostAddr_ff == 16'h0000 && hostCycle_ff == 2'b00)
      else $error("lines driven while off");
   AST_CYCLE: assert property (dmaLoad ##1 drive_address_out |=> hostCycle_ff == $past(microWord[9:8], 2))
      else $error("cycle type wrong");
   AST_SRC_OFF: assert property (!(isTransfer || isRamOp) |=> xferBus_ff == 16'h0000) else $error("bus not idle");
   AST_RES_HOLD: assert property ($changed(aluResult_ff) |-> $past(isAluOp && dataStrobe))
      else $error("result moved");
   AST_BCC_HOLD: assert property ($changed(block_check_result) |-> $past(isBccCalc && dataStrobe))
      else $error("check result moved");
   AST_PEND_FULL: assert property (fifoFull_ff && $past(fifoFull_ff) |-> !charPending_ff)
      else $error("pending while full");
   AST_GATE_SET: assert property (scHit && microWord[7:0] == `MDS_SC_GATE_SET |=> rxGate_ff)
      else $error("gate not set");
   AST_RESYNC_SET: assert property (scHit && microWord[7:0] == `MDS_SC_RESYNC |=> resync_ff)
      else $error("resync not set");
   AST_RESYNC_CLR: assert property (scHit && microWord[7:0] == `MDS_SC_SCAN_ADV |=> !resync_ff)
      else $error("resync not cleared");
   AST_FLAGS: assert property (!(fifoFull_ff && fifoEmpty_ff)) else $error("full and empty");
   COV_FULL: cover property ($rose(fifoFull_ff));
   COV_DRIVE: cover property (dmaLoad ##1 drive_address_out);
   COV_RESYNC: cover property ($rose(resync_ff));
endmodule // mds_datapath_sva
bind mds_datapath mds_datapath_sva i_sva (.clk(clk), .sys_rst(sys_rst), .microWord(microWord),
   .isTransfer(isTransfer), .isAluOp(isAluOp), .isRamOp(isRamOp), .isSetClr(isSetClr), .isBccCalc(isBccCalc),
   .phase02(phase02), .dataStrobe(dataStrobe), .drive_address_out(drive_address_out), .hostAddr_ff(hostAddr_ff),
   .hostAddrOe_ff(hostAddrOe_ff), .hostCycle_ff(hostCycle_ff), .xferBus_ff(xferBus_ff),
   .aluResult_ff(aluResult_ff), .block_check_result(block_check_result), .dma_address_reg(dma_address_reg),
   .charPending_ff(charPending_ff), .rxGate_ff(rxGate_ff), .resync_ff(resync_ff),
   .fifoFull_ff(fifoFull_ff), .fifoEmpty_ff(fifoEmpty_ff));
`default_nettype wire

/* File: verif/tb_mux_microcode_datapath_silo.sv */
// Purpose: Self-checking bench for the datapath.
// Assumes: Receiver model on the far side; phase strobes driven by the bench.
// Notes: Pushes are spaced beyond the push pulse window.
`timescale 1ns/1ps
`default_nettype none
`include "mds_map.vh"
module tb_mux_microcode_datapath_silo;
   logic clk, sys_rst, isTransfer, isAluOp, isRamOp, isSetClr, isBccCalc, phase02, dataStrobe;
   logic drive_address_out, have, nextPar, nextOvr;
   logic [15:0] microWord, ramOutData;
   logic [7:0] nextChar;
   logic [3:0] scanLine;
   wire [7:0] rxChar;
   wire rxParityErr, rxOverrun, rxReady, hostAddrOe_ff, charPending_ff, rxGate_ff, resync_ff;
   wire fifoFull_ff, fifoEmpty_ff, scanAdvance_ff;
   wire [1:0] hostCycle_ff;
   wire [15:0] hostAddr_ff, xferBus_ff, aluResult_ff, block_check_result, dma_address_reg;
   int n_mismatch = 0;
   int n_compared = 0;
   mds_rx_model i_rx (.gate(rxGate_ff), .have(have), .nextChar(nextChar), .nextPar(nextPar),
      .nextOvr(nextOvr), .rxChar(rxChar), .rxParityErr(rxParityErr), .rxOverrun(rxOverrun), .rxReady(rxReady));
   mds_datapath i_dut (.clk(clk), .sys_rst(sys_rst), .microWord(microWord), .isTransfer(isTransfer),
      .isAluOp(isAluOp), .isRamOp(isRamOp), .isSetClr(isSetClr), .isBccCalc(isBccCalc), .phase02(phase02),
      .dataStrobe(dataStrobe), .ramOutData(ramOutData), .rxChar(rxChar), .rxParityErr(rxParityErr),
      .rxOverrun(rxOverrun), .rxReady(rxReady), .scanLine(scanLine), .drive_address_out(drive_address_out),
      .hostAddr_ff(hostAddr_ff), .hostAddrOe_ff(hostAddrOe_ff), .hostCycle_ff(hostCycle_ff),
      .xferBus_ff(xferBus_ff), .aluResult_ff(aluResult_ff), .block_check_result(block_check_result),
      .dma_address_reg(dma_address_reg), .charPending_ff(charPending_ff), .rxGate_ff(rxGate_ff),
      .resync_ff(resync_ff), .fifoFull_ff(fifoFull_ff), .fifoEmpty_ff(fifoEmpty_ff),
      .scanAdvance_ff(scanAdvance_ff));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [15:0] xw(input logic [1:0] c, input logic [3:0] s, input logic [2:0] d);
      return {6'h00, c, s, 1'b0, d};
   endfunction
   // Presents one microinstruction for one cycle, then returns just after the edge that took it.
   task automatic op(input logic [15:0] w, input logic tr, input logic ram, input logic sc, input logic calc);
      @(posedge clk);
      microWord <= w;
      isTransfer <= tr;
      isRamOp <= ram;
      isSetClr <= sc;
      isAluOp <= calc;
      isBccCalc <= calc;
      phase02 <= tr | ram;
      dataStrobe <= sc | calc;
      @(posedge clk);
      {isTransfer, isRamOp, isSetClr, isAluOp, isBccCalc, phase02, dataStrobe} <= 7'h00;
      #1;
   endtask
   task automatic pushc(input logic [7:0] c, input logic p, input logic o);
      nextChar <= c;
      nextPar <= p;
      nextOvr <= o;
      op({8'h00, `MDS_SC_GATE_SET}, 0, 0, 1, 0);
      repeat (3) @(posedge clk);
      op({8'h00, `MDS_SC_PUSH}, 0, 0, 1, 0);
      repeat (24) @(posedge clk);
   endtask
   task automatic t_xfer;
      int k;
      nextChar <= 8'h5a;
      op({8'h00, `MDS_SC_GATE_SET}, 0, 0, 1, 0);
      repeat (4) @(posedge clk);
      op(xw(2'b00, `MDS_SRC_RXCHR, `MDS_DST_A), 1, 0, 0, 0);
      chk("xferBus", 16'h005a, xferBus_ff);
      op(xw(2'b00, `MDS_SRC_A, `MDS_DST_B), 1, 0, 0, 0);
      op(xw(2'b00, `MDS_SRC_B, `MDS_DST_SCRATCH), 1, 0, 0, 0);
      chk("B via A", 16'h005a, xferBus_ff);
      op(xw(2'b10, `MDS_SRC_B, `MDS_DST_DMA), 1, 0, 0, 0);
      chk("dma_address_reg", 16'h005a, dma_address_reg);
      @(posedge clk) drive_address_out <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("hostAddr", 16'h005a, hostAddr_ff);
      chk("hostCycle", 16'h0002, {14'h0000, hostCycle_ff});
      @(posedge clk) drive_address_out <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("hostAddrOe off", 16'h0000, {15'h0000, hostAddrOe_ff});
      op(xw(2'b00, `MDS_SRC_RXCHR, `MDS_DST_SCRATCH), 0, 1, 0, 0);
      chk("ram source", 16'h005a, xferBus_ff);
      for (k = 0; k < 4; k++) begin
         ramOutData <= {11'h000, k[1:0], 3'h0};
         op(16'h0010 + k[15:0], 0, 0, 0, 1);
         chk("aluResult", (k == 0) ? 16'h005b : (k == 1) ? 16'h00b5 : 16'h0000, aluResult_ff);
         if (k > 1) chk("block_check_result", (k == 3) ? 16'h00b4 : 16'h0000, block_check_result);
      end
      $display("test transfer done");
   endtask
   task automatic t_fifo;
      int k;
      op({8'h00, `MDS_SC_GATE_SET}, 0, 0, 1, 0);
      chk("rxGate", 16'h0001, {15'h0000, rxGate_ff});
      pushc(8'hc1, 1'b1, 1'b0);
      for (k = 0; k < 2; k++) begin
         op(xw(2'b00, `MDS_SRC_FIFO, `MDS_DST_SCRATCH), 1, 0, 0, 0);
         chk("fifo head", 16'h25c1, xferBus_ff);
      end
      op({8'h00, `MDS_SC_RESYNC}, 0, 0, 1, 0);
      chk("resync", 16'h0001, {15'h0000, resync_ff});
      pushc(8'h77, 1'b0, 1'b1);
      op({8'h00, `MDS_SC_SCAN_ADV}, 0, 0, 1, 0);
      chk("resync cleared", 16'h0000, {15'h0000, resync_ff});
      op({8'h00, `MDS_SC_POP}, 0, 0, 1, 0);
      op(xw(2'b00, `MDS_SRC_FIFO, `MDS_DST_SCRATCH), 1, 0, 0, 0);
      chk("fifo second", 16'hc577, xferBus_ff);
      for (k = 0; k < 2; k++) op({8'h00, `MDS_SC_POP}, 0, 0, 1, 0);
      chk("empty after pops", 16'h0001, {15'h0000, fifoEmpty_ff});
      have <= 1'b1;
      k = 0;
      while (charPending_ff !== 1'b1 && k < 8) begin
         @(posedge clk);
         k++;
      end
      chk("charPending", 16'h0001, {15'h0000, charPending_ff});
      if (k == 8) print_verdict;
      $display("test fifo done");
   endtask
   task automatic t_full;
      int k;
      for (k = 0; k < 128; k++) pushc(k[7:0], 1'b0, 1'b0);
      chk("full", 16'h0001, {15'h0000, fifoFull_ff});
      repeat (3) @(posedge clk);
      chk("pending when full", 16'h0000, {15'h0000, charPending_ff});
      pushc(8'hee, 1'b0, 1'b0);
      op(xw(2'b00, `MDS_SRC_FIFO, `MDS_DST_SCRATCH), 1, 0, 0, 0);
      chk("oldest kept", 16'h0500, xferBus_ff);
      op({8'h00, `MDS_SC_POP}, 0, 0, 1, 0);
      op(xw(2'b00, `MDS_SRC_FIFO, `MDS_DST_SCRATCH), 1, 0, 0, 0);
      chk("next after pop", 16'h0501, xferBus_ff);
      $display("test full done");
   endtask
   initial begin
      sys_rst = 1'b1;
      microWord = 16'h0000;
      ramOutData = 16'h0000;
      {isTransfer, isAluOp, isRamOp, isSetClr, isBccCalc, phase02, dataStrobe} = 7'h00;
      {drive_address_out, have, nextPar, nextOvr} = 4'h0;
      nextChar = 8'h00;
      scanLine = 4'h5;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("fifoEmpty reset", 16'h0001, {15'h0000, fifoEmpty_ff});
      chk("dma reset", 16'h0000, dma_address_reg);
      t_xfer();
      t_fifo();
      t_full();
      print_verdict();
   end
endmodule // tb_mux_microcode_datapath_silo
`default_nettype wire
